//--- dpr_map.svh
// Register map, field values and timing counts of the power regulation block.
// Assumes APB byte addressing, one 32-bit word per register.
`ifndef DPR_MAP_SVH
`define DPR_MAP_SVH
// Register word indices; the byte address is four times the index
`define DPR_IDX_REG_CONFIG 8'h68
`define DPR_IDX_TARGET_CURRENT 8'h69
`define DPR_IDX_LOAD_MARGIN 8'h6B
`define DPR_IDX_UNLOAD_MARGIN 8'h6E
`define DPR_IDX_SUPPLY_LOW_LIMIT 8'h6F
`define DPR_IDX_DRIVER_CONDUCTANCE 8'h70
`define DPR_IDX_LOW_LIMIT_MODE 8'h71
`define DPR_IDX_INIT_DRIVER 8'h72
`define DPR_IDX_MAX_DROPOUT 8'h73
`define DPR_IDX_GUARD_TIME 8'h79
`define DPR_IDX_FDT_ENABLE 8'h7A
`define DPR_IDX_POST_RX_ENABLE 8'h7B
`define DPR_IDX_STATUS 8'h7C
`define DPR_RST_LOAD_MARGIN 8'h0A
`define DPR_RST_UNLOAD_MARGIN 8'h0A
`define DPR_RST_TARGET_CURRENT 16'h00C8
`define DPR_RST_MAX_DROPOUT 16'h0E10
`define DPR_RST_GUARD_TIME 8'h0A
`define DPR_RST_ENABLE 8'h01
`define DPR_RST_REG_CONFIG 8'h07
`define DPR_CONDUCTANCE_LIMIT 8'h14
`define DPR_MODE_DISABLED 8'h00
`define DPR_MODE_ON_RES 8'h01
`define DPR_MODE_PULSE_WIDTH 8'h02
`define DPR_ENABLE_ON 8'h01
`define DPR_CLOCK_HZ 20000000
`define DPR_GUARD_UNIT_NS 1000
`define DPR_CLOCK_PERIOD_NS 50
`define DPR_CYCLES_PER_US (`DPR_GUARD_UNIT_NS / `DPR_CLOCK_PERIOD_NS)
`define DPR_SUPPLY_MAX 8'hFF
`define DPR_SAFE_SUPPLY 8'h40
`endif

//--- dpr_pkg.sv
// Types of the power regulation block.
// Constants live in dpr_map.svh.
package dpr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE_REG = 3'b001,
    ST_PRE_GUARD = 3'b011,
    ST_POST_GUARD = 3'b010,
    ST_POST_REG = 3'b110
  } dpr_state_t;

  typedef struct packed {
    logic [7:0] load_current_margin;
    logic [7:0] unload_current_margin;
    logic [7:0] supply_low_limit;
    logic [7:0] driver_conductance;
    logic [7:0] low_limit_control_mode;
    logic [7:0] initial_driver_strength;
    logic [15:0] max_regulator_dropout;
    logic [7:0] regulation_guard_time;
    logic [7:0] frame_delay_regulation_enable;
    logic [7:0] post_receive_guard_enable;
    logic [2:0] reg_config;
    logic [15:0] target_current;
  } dpr_regs_t;

  typedef struct packed {
    dpr_regs_t regs;
    dpr_state_t state;
    logic [15:0] guard_cnt;
    logic [7:0] supply_setpoint;
    logic [7:0] driver_strength;
    logic [7:0] on_resistance_code;
    logic supply_stop;
    logic tx_start;
    logic reg_done;
    logic field_on_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dpr_state_all_t;
endpackage

//--- dpr_supply_model.sv
// Behavioural supply regulator and current sense facing the block.
// Assumes the bench chooses the load current and the dropout to be seen.
`timescale 1ns/10ps
module dpr_supply_model (
  input wire logic clock,
  input wire logic [7:0] supply_setpoint,
  input wire logic [15:0] load_ma,
  input wire logic [15:0] dropout_mv,
  output logic [15:0] measured_current,
  output logic [15:0] regulator_dropout
);
  // Sense lags one cycle; a zero supply setpoint shows no dropout
  always_ff @(posedge clock) begin
    measured_current <= load_ma;
    regulator_dropout <= (supply_setpoint == 8'h00) ? 16'h0000 : dropout_mv;
  end
endmodule

//--- dpr_top.sv
// Dynamic power regulation of the transmitter supply, with APB register slave.
// Assumes all inputs but arst_n synchronous to clock; current and dropout measured elsewhere.
// Summary of operation
// - Current above target plus loading margin lowers the supply one step.
// - Current below target minus unloading margin raises the supply one step.
// - Loading and unloading margins are separate 8-bit milliampere values.
// - Conductance below 20 gives 10 ohm over setting plus one, else 0.5 ohm.
// - Low-limit mode: 0 disabled, 1 on-resistance, 2 pulse width, others reserved; mode 2 applies no limit here.
// - 8-bit supply low limit bounds the supply in on-resistance mode.
// - Field on loads the single driver strength output with the initial driver strength.
// - Dropout over threshold at first field on: safe level, or stop if bypassing.
// - Guard time is an 8-bit count of microseconds.
// - Regulation runs once before each transmit and once after each receive with the post-receive enable set.
// - Guard time passes between regulation done and transmit start.
// - Guard time passes between receive end and regulation start.
// - Guard time before transmit applies whatever the enables say.
// - Frame-delay enable: 0 disabled, 1 enabled, others reserved.
// - Post-receive enable: 0 disabled, 1 enabled, others reserved.
// - Target current is a 16-bit milliampere value.
// - Config bits 0, 1, 2 enable reader, active initiator, active target modes.
`timescale 1ns/10ps
`include "dpr_map.svh"
module dpr_top #(
  parameter int unsigned CYCLES_PER_US = `DPR_CYCLES_PER_US
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] rf_mode,
  input wire logic field_on,
  input wire logic tx_request,
  input wire logic rx_end,
  input wire logic in_fdt,
  input wire logic boost_bypass,
  input wire logic [15:0] measured_current,
  input wire logic [15:0] regulator_dropout,
  output logic [7:0] supply_setpoint,
  output logic supply_stop,
  output logic [7:0] driver_strength,
  output logic [7:0] on_resistance_code,
  output logic tx_start,
  output logic reg_done
);
  logic rst_s1_q;
  logic rst_q;
  dpr_pkg::dpr_state_all_t s_q;
  dpr_pkg::dpr_state_all_t s_d;
  logic [8:0] word_idx;
  logic access;
  logic mode_en;
  logic reg_allowed;
  logic [16:0] upper_lim;
  logic [16:0] lower_lim;
  logic [7:0] floor_v;
  logic [16:0] guard_cycles;
  logic field_rise;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end

  // On-resistance code in 0.05 ohm units: 200 / (n+1), fixed 0.5 ohm from 20 up
  function automatic logic [7:0] conductance_code(input logic [7:0] n);
    logic [8:0] den;
    den = {1'b0, n} + 9'h001;
    if (n < `DPR_CONDUCTANCE_LIMIT) begin
      conductance_code = 8'(9'h0C8 / den);
    end else begin
      conductance_code = 8'h0A;
    end
  endfunction

  function automatic logic [15:0] guard_count(input logic [7:0] us);
    guard_count = 16'(32'(us) * CYCLES_PER_US);
  endfunction

  assign word_idx = 9'(paddr[11:2]);
  assign access = psel && penable;
  assign field_rise = field_on && !s_q.field_on_prev;
  // Per-mode enable
  assign mode_en = |(rf_mode & s_q.regs.reg_config);
  assign reg_allowed = mode_en && !(in_fdt && s_q.regs.frame_delay_regulation_enable != `DPR_ENABLE_ON);
  assign upper_lim = {1'b0, s_q.regs.target_current} + 17'(s_q.regs.load_current_margin);
  // Clamped at zero: a margin above the target must not wrap into an always-true raise
  assign lower_lim = (s_q.regs.target_current >= 16'(s_q.regs.unload_current_margin)) ?
    {1'b0, s_q.regs.target_current} - 17'(s_q.regs.unload_current_margin) : 17'h00000;
  // Floor applies only in on-resistance mode
  assign floor_v = (s_q.regs.low_limit_control_mode == `DPR_MODE_ON_RES) ? s_q.regs.supply_low_limit : 8'h00;
  assign guard_cycles = 17'(guard_count(s_q.regs.regulation_guard_time));

  always_comb begin
    s_d = s_q;
    s_d.tx_start = 1'b0;
    s_d.reg_done = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.field_on_prev = field_on;
    s_d.on_resistance_code = conductance_code(s_q.regs.driver_conductance);
    case (s_q.state)
      dpr_pkg::ST_IDLE: begin
        if (tx_request) begin
          s_d.state = dpr_pkg::ST_PRE_REG;
        end else if (rx_end && s_q.regs.post_receive_guard_enable == `DPR_ENABLE_ON) begin
          s_d.state = dpr_pkg::ST_POST_GUARD;
          s_d.guard_cnt = 16'h0000;
        end
      end
      dpr_pkg::ST_PRE_REG, dpr_pkg::ST_POST_REG: begin
        // One step per scheduled point avoids oscillation on a slow supply
        if (reg_allowed) begin
          if (17'(measured_current) > upper_lim && s_q.supply_setpoint > floor_v) begin
            s_d.supply_setpoint = s_q.supply_setpoint - 8'h01;
          end else if (17'(measured_current) < lower_lim && s_q.supply_setpoint != `DPR_SUPPLY_MAX) begin
            s_d.supply_setpoint = s_q.supply_setpoint + 8'h01;
          end
        end
        s_d.reg_done = 1'b1;
        s_d.guard_cnt = 16'h0000;
        // Guard before transmit regardless of enables
        s_d.state = (s_q.state == dpr_pkg::ST_PRE_REG) ? dpr_pkg::ST_PRE_GUARD : dpr_pkg::ST_IDLE;
      end
      dpr_pkg::ST_PRE_GUARD: begin
        if (17'(s_q.guard_cnt) + 17'h00001 >= guard_cycles) begin
          s_d.tx_start = 1'b1;
          s_d.state = dpr_pkg::ST_IDLE;
        end else begin
          s_d.guard_cnt = s_q.guard_cnt + 16'h0001;
        end
      end
      dpr_pkg::ST_POST_GUARD: begin
        if (17'(s_q.guard_cnt) + 17'h00001 >= guard_cycles) begin
          s_d.state = dpr_pkg::ST_POST_REG;
        end else begin
          s_d.guard_cnt = s_q.guard_cnt + 16'h0001;
        end
      end
      default: s_d.state = dpr_pkg::ST_IDLE;
    endcase
    // Field rising edge: initial drivers and dropout check
    // Placed after the regulation step so the safe level wins in a shared cycle
    if (field_rise) begin
      s_d.driver_strength = s_q.regs.initial_driver_strength;
      s_d.supply_stop = 1'b0;
      if (regulator_dropout > s_q.regs.max_regulator_dropout) begin
        if (boost_bypass) begin
          s_d.supply_stop = 1'b1;
        end else begin
          s_d.supply_setpoint = `DPR_SAFE_SUPPLY;
        end
      end
    end
    // APB: single-cycle wait, answer one cycle after access phase begins
    if (access && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      case (word_idx)
        9'(`DPR_IDX_REG_CONFIG): begin
          if (pwrite) s_d.regs.reg_config = pwdata[2:0];
          s_d.prdata = 32'(s_q.regs.reg_config);
        end
        9'(`DPR_IDX_TARGET_CURRENT): begin
          if (pwrite) s_d.regs.target_current = pwdata[15:0];
          s_d.prdata = 32'(s_q.regs.target_current);
        end
        9'(`DPR_IDX_LOAD_MARGIN): begin
          if (pwrite) s_d.regs.load_current_margin = pwdata[7:0];
          s_d.prdata = 32'(s_q.regs.load_current_margin);
        end
        9'(`DPR_IDX_UNLOAD_MARGIN): begin
          if (pwrite) s_d.regs.unload_current_margin = pwdata[7:0];
          s_d.prdata = 32'(s_q.regs.unload_current_margin);
        end
        9'(`DPR_IDX_SUPPLY_LOW_LIMIT): begin
          if (pwrite) s_d.regs.supply_low_limit = pwdata[7:0];
          s_d.prdata = 32'(s_q.regs.supply_low_limit);
        end
        9'(`DPR_IDX_DRIVER_CONDUCTANCE): begin
          if (pwrite) s_d.regs.driver_conductance = pwdata[7:0];
          s_d.prdata = 32'(s_q.regs.driver_conductance);
        end
        9'(`DPR_IDX_LOW_LIMIT_MODE): begin
          if (pwrite) s_d.regs.low_limit_control_mode = pwdata[7:0];
          s_d.prdata = 32'(s_q.regs.low_limit_control_mode);
        end
        9'(`DPR_IDX_INIT_DRIVER): begin
          if (pwrite) s_d.regs.initial_driver_strength = pwdata[7:0];
          s_d.prdata = 32'(s_q.regs.initial_driver_strength);
        end
        9'(`DPR_IDX_MAX_DROPOUT): begin
          if (pwrite) s_d.regs.max_regulator_dropout = pwdata[15:0];
          s_d.prdata = 32'(s_q.regs.max_regulator_dropout);
        end
        9'(`DPR_IDX_GUARD_TIME): begin
          if (pwrite) s_d.regs.regulation_guard_time = pwdata[7:0];
          s_d.prdata = 32'(s_q.regs.regulation_guard_time);
        end
        9'(`DPR_IDX_FDT_ENABLE): begin
          if (pwrite) s_d.regs.frame_delay_regulation_enable = pwdata[7:0];
          s_d.prdata = 32'(s_q.regs.frame_delay_regulation_enable);
        end
        9'(`DPR_IDX_POST_RX_ENABLE): begin
          if (pwrite) s_d.regs.post_receive_guard_enable = pwdata[7:0];
          s_d.prdata = 32'(s_q.regs.post_receive_guard_enable);
        end
        9'(`DPR_IDX_STATUS): begin
          s_d.prdata = {12'h000, s_q.supply_stop, s_q.on_resistance_code, s_q.supply_setpoint, s_q.state};
          s_d.pslverr = pwrite;
        end
        default: s_d.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      s_q <= '0;
      s_q.regs.load_current_margin <= `DPR_RST_LOAD_MARGIN;
      s_q.regs.unload_current_margin <= `DPR_RST_UNLOAD_MARGIN;
      s_q.regs.target_current <= `DPR_RST_TARGET_CURRENT;
      s_q.regs.max_regulator_dropout <= `DPR_RST_MAX_DROPOUT;
      s_q.regs.regulation_guard_time <= `DPR_RST_GUARD_TIME;
      s_q.regs.frame_delay_regulation_enable <= `DPR_RST_ENABLE;
      s_q.regs.post_receive_guard_enable <= `DPR_RST_ENABLE;
      s_q.regs.reg_config <= 3'(`DPR_RST_REG_CONFIG);
      s_q.supply_setpoint <= `DPR_SUPPLY_MAX;
      s_q.state <= dpr_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign supply_setpoint = s_q.supply_setpoint;
  assign supply_stop = s_q.supply_stop;
  assign driver_strength = s_q.driver_strength;
  assign on_resistance_code = s_q.on_resistance_code;
  assign tx_start = s_q.tx_start;
  assign reg_done = s_q.reg_done;

  // Step checks leave out a field rise, which takes the supply over that cycle
  a_step_down: assert property (@(posedge clock) disable iff (!rst_q)
    ((s_q.state == dpr_pkg::ST_PRE_REG || s_q.state == dpr_pkg::ST_POST_REG) && reg_allowed
     && 17'(measured_current) > upper_lim && s_q.supply_setpoint > floor_v && !field_rise)
    |=> supply_setpoint == $past(supply_setpoint) - 8'h01)
    else $error("Supply not lowered on overload");
  a_step_up: assert property (@(posedge clock) disable iff (!rst_q)
    ((s_q.state == dpr_pkg::ST_PRE_REG || s_q.state == dpr_pkg::ST_POST_REG) && reg_allowed
     && 17'(measured_current) < lower_lim && 17'(measured_current) <= upper_lim && supply_setpoint != 8'hFF
     && !field_rise) |=> supply_setpoint == $past(supply_setpoint) + 8'h01)
    else $error("Supply not raised on unload");
  a_floor_kept: assert property (@(posedge clock) disable iff (!rst_q)
    supply_setpoint < $past(supply_setpoint) && !$past(field_rise) |-> supply_setpoint >= $past(floor_v))
    else $error("Supply below low limit");
  // Independent of the floor signal: reads the low-limit registers directly
  a_floor_on_res: assert property (@(posedge clock) disable iff (!rst_q)
    (s_q.state == dpr_pkg::ST_PRE_REG || s_q.state == dpr_pkg::ST_POST_REG) && !field_rise
    && s_q.regs.low_limit_control_mode == 8'h01 && supply_setpoint <= s_q.regs.supply_low_limit
    |=> supply_setpoint >= $past(supply_setpoint))
    else $error("Supply lowered below on-resistance limit");
  a_pulse_no_floor: assert property (@(posedge clock) disable iff (!rst_q)
    (s_q.state == dpr_pkg::ST_PRE_REG || s_q.state == dpr_pkg::ST_POST_REG) && !field_rise
    && s_q.regs.low_limit_control_mode == 8'h02 && reg_allowed && 17'(measured_current) > upper_lim
    && supply_setpoint != 8'h00 |=> supply_setpoint == $past(supply_setpoint) - 8'h01)
    else $error("Low limit applied outside on-resistance mode");
  a_init_drive: assert property (@(posedge clock) disable iff (!rst_q)
    field_rise |=> driver_strength == $past(s_q.regs.initial_driver_strength))
    else $error("Driver not loaded at field on");
  a_dropout_stop: assert property (@(posedge clock) disable iff (!rst_q)
    field_rise && regulator_dropout > s_q.regs.max_regulator_dropout && boost_bypass |=> supply_stop)
    else $error("Supply not stopped on dropout");
  a_dropout_safe: assert property (@(posedge clock) disable iff (!rst_q)
    field_rise && regulator_dropout > s_q.regs.max_regulator_dropout && !boost_bypass
    |=> supply_setpoint == `DPR_SAFE_SUPPLY && !supply_stop)
    else $error("Supply not lowered to safe level on dropout");
  a_stop_held: assert property (@(posedge clock) disable iff (!rst_q)
    supply_stop && !field_rise |=> supply_stop)
    else $error("Supply stop dropped without a new field on");
  a_cond_high: assert property (@(posedge clock) disable iff (!rst_q)
    s_q.regs.driver_conductance >= 8'h14 |=> on_resistance_code == 8'h0A)
    else $error("Wrong fixed conductance");
  a_cond_low: assert property (@(posedge clock) disable iff (!rst_q)
    s_q.regs.driver_conductance < 8'h14
    |=> on_resistance_code == 8'hC8 / ($past(s_q.regs.driver_conductance) + 8'h01))
    else $error("Wrong scaled conductance");
  // One pulse per scheduled point; a held pulse would start two transfers
  a_one_reg: assert property (@(posedge clock) disable iff (!rst_q)
    reg_done |=> !reg_done)
    else $error("Regulation ran twice in a row");
  a_one_tx: assert property (@(posedge clock) disable iff (!rst_q)
    tx_start |=> !tx_start)
    else $error("Transmit start longer than one cycle");
  a_one_step: assert property (@(posedge clock) disable iff (!rst_q)
    $changed(supply_setpoint) && !$past(field_rise)
    |-> $past(s_q.state == dpr_pkg::ST_PRE_REG || s_q.state == dpr_pkg::ST_POST_REG)
    && (supply_setpoint == $past(supply_setpoint) + 8'h01 || supply_setpoint == $past(supply_setpoint) - 8'h01))
    else $error("Supply moved outside a single scheduled step");
  // Guard checks pin the full-rate setting and the short one used in quick runs
  a_tx_guard: assert property (@(posedge clock) disable iff (!rst_q)
    reg_done && s_q.state == dpr_pkg::ST_PRE_GUARD && s_q.regs.regulation_guard_time == 8'h01
    && CYCLES_PER_US == 20 |-> ##20 tx_start)
    else $error("Transmit start not after guard time");
  a_tx_guard_short: assert property (@(posedge clock) disable iff (!rst_q)
    reg_done && s_q.state == dpr_pkg::ST_PRE_GUARD && guard_cycles == 17'h00006
    |-> !tx_start [*6] ##1 tx_start)
    else $error("Transmit start not after short guard time");
  a_rx_guard: assert property (@(posedge clock) disable iff (!rst_q)
    s_q.state == dpr_pkg::ST_IDLE && !tx_request && rx_end && s_q.regs.post_receive_guard_enable == 8'h01
    && guard_cycles == 17'h00006 |=> !reg_done [*7] ##1 reg_done)
    else $error("Regulation after receive not after guard time");
  a_rx_off: assert property (@(posedge clock) disable iff (!rst_q)
    s_q.state == dpr_pkg::ST_IDLE && !tx_request && rx_end && s_q.regs.post_receive_guard_enable != 8'h01
    |=> s_q.state == dpr_pkg::ST_IDLE)
    else $error("Regulation started with post-receive guard disabled");
  // Regulation skipped when disabled for the frame delay or the current mode
  a_fdt_off: assert property (@(posedge clock) disable iff (!rst_q)
    (s_q.state == dpr_pkg::ST_PRE_REG || s_q.state == dpr_pkg::ST_POST_REG) && in_fdt
    && s_q.regs.frame_delay_regulation_enable != 8'h01 && !field_rise |=> $stable(supply_setpoint))
    else $error("Regulation ran in frame delay time while disabled");
  a_mode_off: assert property (@(posedge clock) disable iff (!rst_q)
    (s_q.state == dpr_pkg::ST_PRE_REG || s_q.state == dpr_pkg::ST_POST_REG)
    && (rf_mode & s_q.regs.reg_config) == 3'h0 && !field_rise |=> $stable(supply_setpoint))
    else $error("Regulation ran in a disabled mode");
  // Bus answers in the cycle after the access phase starts
  a_apb_wait: assert property (@(posedge clock) disable iff (!rst_q)
    psel && penable && !pready |=> pready)
    else $error("APB answer late");
endmodule

//--- dpr_top_tb.sv
// Self-checking bench of the power regulation block.
// Assumes APB slave answers after a two-cycle access phase.
`timescale 1ns/10ps
`include "dpr_map.svh"
module dpr_top_tb;
  localparam int CPU = 2;
  localparam int GUARD = 3;
  logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, field_on = 0, tx_request = 0, rx_end = 0, in_fdt = 0, boost_bypass = 0;
  logic [2:0] rf_mode = 3'h1;
  logic [15:0] load_ma = 16'h00C8, dropout_mv = 16'h0000, measured_current, regulator_dropout;
  logic [7:0] supply_setpoint, driver_strength, on_resistance_code;
  logic supply_stop, tx_start, reg_done;
  int failures = 0, cmp_count = 0, cycles = 0, done_cnt = 0;

  dpr_top #(.CYCLES_PER_US(CPU)) i_dpr_top (.clock(clock), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rf_mode(rf_mode), .field_on(field_on),
    .tx_request(tx_request), .rx_end(rx_end), .in_fdt(in_fdt), .boost_bypass(boost_bypass),
    .measured_current(measured_current), .regulator_dropout(regulator_dropout),
    .supply_setpoint(supply_setpoint), .supply_stop(supply_stop), .driver_strength(driver_strength),
    .on_resistance_code(on_resistance_code), .tx_start(tx_start), .reg_done(reg_done));
  dpr_supply_model i_dpr_supply_model (.clock(clock), .supply_setpoint(supply_setpoint),
    .load_ma(load_ma), .dropout_mv(dropout_mv), .measured_current(measured_current),
    .regulator_dropout(regulator_dropout));

  always #25 clock = ~clock;
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (reg_done === 1'b1) done_cnt++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, wd, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 32'h0, rd, err);
    chk(rd, exp);
    chk(err, exp_err);
  endtask

  task automatic wait_pulse(input bit sel, output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((sel ? tx_start : reg_done) !== 1'b1 && n < 2000);
  endtask

  task automatic run_tx(input logic [7:0] exp_sp);
    int n, d0;
    d0 = done_cnt;
    @(posedge clock);
    tx_request <= 1'b1;
    @(posedge clock);
    tx_request <= 1'b0;
    wait_pulse(0, n);
    chk(supply_setpoint, exp_sp);
    wait_pulse(1, n);
    chk(n, GUARD * CPU);
    chk(done_cnt - d0, 1);
  endtask

  task automatic run_rx(input logic [7:0] exp_sp, input bit active);
    int n, d0;
    d0 = done_cnt;
    @(posedge clock);
    rx_end <= 1'b1;
    @(posedge clock);
    rx_end <= 1'b0;
    if (active) begin
      wait_pulse(0, n);
      chk(n >= GUARD * CPU && n <= GUARD * CPU + 3, 1);
      chk(supply_setpoint, exp_sp);
    end else repeat (40) @(posedge clock);
    // Let the pulse counter catch up with the edge that ended the wait
    @(posedge clock);
    chk(done_cnt - d0, active);
  endtask

  task automatic t_registers();
    logic [7:0] ix [9] = '{8'h6B, 8'h6E, 8'h73, 8'h79, 8'h7A, 8'h7B, 8'h68, 8'h69, 8'h10};
    logic [31:0] ev [9] = '{32'h0A, 32'h0A, 32'h0E10, 32'h0A, 32'h01, 32'h01, 32'h07, 32'hC8, 32'h0};
    logic [31:0] rd;
    logic err;
    for (int i = 0; i < 9; i++) rd_chk(ix[i], ev[i], i == 8);
    apb(1'b1, 8'h7C, 32'h0, rd, err);
    chk(err, 1'b1);
    wr(8'h79, GUARD);
    wr(8'h72, 32'h5A);
    rd_chk(8'h72, 32'h5A, 1'b0);
  endtask

  task automatic t_conductance();
    logic [7:0] vals [5] = '{8'h00, 8'h05, 8'h13, 8'h14, 8'hFF};
    for (int i = 0; i < 5; i++) begin
      wr(8'h70, vals[i]);
      repeat (2) @(posedge clock);
      chk(on_resistance_code, (vals[i] < 20) ? 200 / (vals[i] + 1) : 10);
    end
  endtask

  task automatic t_regulate();
    load_ma <= 16'd300;
    run_tx(8'hFE);
    load_ma <= 16'd100;
    run_rx(8'hFF, 1);
    wr(8'h7B, 32'h0);
    run_rx(8'hFF, 0);
    wr(8'h7B, 32'h1);
    load_ma <= 16'd300;
    wr(8'h7A, 32'h0);
    in_fdt <= 1'b1;
    run_tx(8'hFF);
    wr(8'h68, 32'h6);
    in_fdt <= 1'b0;
    run_tx(8'hFF);
    wr(8'h68, 32'h7);
    wr(8'h7A, 32'h1);
    // Exactly on the margin edge no step is due
    load_ma <= 16'd210;
    run_tx(8'hFF);
    wr(8'h6B, 32'h5);
    run_tx(8'hFE);
    load_ma <= 16'd190;
    run_rx(8'hFE, 1);
    wr(8'h6E, 32'h5);
    run_rx(8'hFF, 1);
  endtask

  task automatic t_modes();
    load_ma <= 16'd300;
    wr(8'h6F, 32'hFF);
    wr(8'h71, 32'h1);
    run_tx(8'hFF);
    wr(8'h71, 32'h2);
    run_tx(8'hFE);
    wr(8'h71, 32'h0);
    run_tx(8'hFD);
  endtask

  task automatic t_field();
    dropout_mv <= 16'd4000;
    repeat (3) @(posedge clock);
    field_on <= 1'b1;
    repeat (3) @(posedge clock);
    chk(driver_strength, 8'h5A);
    chk(supply_setpoint, `DPR_SAFE_SUPPLY);
    chk(supply_stop, 1'b0);
    field_on <= 1'b0;
    boost_bypass <= 1'b1;
    repeat (3) @(posedge clock);
    field_on <= 1'b1;
    repeat (3) @(posedge clock);
    chk(supply_stop, 1'b1);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_registers();
    t_conductance();
    t_regulate();
    t_modes();
    t_field();
    give_verdict();
  end
endmodule
